// file: ies_sequencer.sv
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
//============================================================
// infeed power-on / power-off sequencer with apb registers
//============================================================
module ies_sequencer #(
   parameter int unsigned EDGE_CYC = ies_pkg::T_EDGE_CYC, // 1 ms lag
   parameter int unsigned SWAP_CYC = ies_pkg::T_SWAP_CYC, // 500 ms
   parameter int unsigned RUN_CYC = ies_pkg::T_RUN_CYC, // 1 s
   parameter int unsigned MS_CYC = ies_pkg::T_MS_CYC // brake tick
) (
   // clock, resets, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic sync_reset,
   // apb slave
   input wire ies_pkg::ies_apb_req_t apb_req,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // control inputs from contacts or controller
   input wire logic start_in,
   input wire logic pulse_en_in,
   input wire logic drive_en_in,
   input wire logic contactor_loop_in,
   // measurements, volts and speed magnitude
   input wire logic [15:0] vdc_link,
   input wire logic [15:0] vline,
   input wire logic [15:0] drive_speed,
   // contactor drives
   output logic precharge_on,
   output logic contactor_loop_out,
   // enable outputs
   output ies_pkg::ies_enables_t enables
);

   //============================================================
   // state
   //============================================================
   // everything that is clocked lives in this one struct
   typedef struct packed {
      ies_pkg::ies_seq_t seq; // sequencer state
      logic [31:0] tmr; // sequence delay counter
      logic line_on; // line contactor request
      logic pre_on; // pre-charge contactor request
      logic int_en; // internal enables issued
      logic brake_done; // drive pulses cancelled
      logic [31:0] ms_div; // brake millisecond prescaler
      logic [15:0] brake_ms; // elapsed brake time, ms
      logic [1:0] brake_ctrl; // cancel selects
      logic [15:0] speed_thr; // cancel speed threshold
      logic [15:0] brake_tmr; // cancel timer stage
      logic [31:0] rdata; // read data held for access phase
   } ies_st_t;

   ies_st_t st_r;
   ies_st_t st_nxt;

   //============================================================
   // delayed enable inputs
   //============================================================
   logic start_lag; // start after 1 ms lag
   logic pulse_lag; // pulse enable after 1 ms lag
   logic drive_lag; // drive enable after 1 ms lag

   // all three inputs share one lag so modules switch together
   ies_lag #(
      .LAG_CYC(EDGE_CYC)
   ) u_lag_start (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .srst(sync_reset),
      .din(start_in),
      .dout(start_lag)
   );

   ies_lag #(
      .LAG_CYC(EDGE_CYC)
   ) u_lag_pulse (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .srst(sync_reset),
      .din(pulse_en_in),
      .dout(pulse_lag)
   );

   ies_lag #(
      .LAG_CYC(EDGE_CYC)
   ) u_lag_drive (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .srst(sync_reset),
      .din(drive_en_in),
      .dout(drive_lag)
   );

   //============================================================
   // charge-complete check
   //============================================================
   logic [23:0] vpeak_raw; // line voltage times 181
   logic [16:0] vpeak; // root-two peak, volts
   logic charged; // both thresholds met

   // peak estimate errs by under 0.1 percent, well inside margin
   always_comb
   begin
      vpeak_raw = vline * 16'(ies_pkg::SQRT2_NUM);
      vpeak = 17'(vpeak_raw >> ies_pkg::SQRT2_SHIFT);
      charged = (vdc_link >= ies_pkg::V_MIN_LINK) &&
                (17'(vdc_link) + 17'(ies_pkg::V_MARGIN) >= vpeak);
   end

   //============================================================
   // apb decode
   //============================================================
   logic setup_ph; // first cycle of a transfer
   logic access_ph; // completing cycle of a transfer
   logic mapped; // address hits a register

   // address decode, used for the error answer only; the read mux decodes the address itself
   function automatic logic is_mapped(input logic [7:0] a);
      return a == ies_pkg::ADDR_STATUS || a == ies_pkg::ADDR_BRAKE_CTRL ||
             a == ies_pkg::ADDR_SPEED_THR || a == ies_pkg::ADDR_BRAKE_TMR;
   endfunction : is_mapped

   assign setup_ph = apb_req.psel && !apb_req.penable;
   assign access_ph = apb_req.psel && apb_req.penable && ce;
   assign mapped = is_mapped(apb_req.paddr);
   // zero wait states; a frozen block simply stretches the access
   assign pready = apb_req.penable && ce;
   assign pslverr = apb_req.psel && apb_req.penable && !mapped;
   assign prdata = st_r.rdata;

   //============================================================
   // next-state logic
   //============================================================
   logic loop_ok; // coil loop closed
   logic tick_ms; // brake millisecond tick
   logic cancel_speed; // speed fell below threshold
   logic cancel_timer; // timer stage expired

   always_comb
   begin
      st_nxt = st_r;
      loop_ok = contactor_loop_in;
      tick_ms = (st_r.ms_div == MS_CYC - 1);
      cancel_speed = st_r.brake_ctrl[ies_pkg::BC_SPEED_BIT] &&
                     (drive_speed < st_r.speed_thr);
      cancel_timer = st_r.brake_ctrl[ies_pkg::BC_TIMER_BIT] &&
                     (st_r.brake_ms >= st_r.brake_tmr);

      // sequencer; start, charge completion, the delay counter and the loop move it
      unique case (st_r.seq)
         // contactors open, waiting for start
         ies_pkg::SEQ_IDLE:
         begin
            st_nxt.tmr = '0;
            if (start_in)
            begin
               st_nxt.seq = ies_pkg::SEQ_CHARGE;
               st_nxt.pre_on = 1'b1;
            end
         end
         // pre-charge runs to completion even if start drops
         ies_pkg::SEQ_CHARGE:
         begin
            if (charged)
            begin
               st_nxt.seq = ies_pkg::SEQ_SETTLE;
               st_nxt.tmr = '0;
            end
         end
         // delays counted from charge completion
         ies_pkg::SEQ_SETTLE:
         begin
            st_nxt.tmr = st_r.tmr + 32'h0000_0001;
            if (st_r.tmr == SWAP_CYC - 1)
            begin
               st_nxt.pre_on = 1'b0;
               st_nxt.line_on = 1'b1;
            end
            if (!start_lag && !start_in && loop_ok)
            begin
               st_nxt.seq = ies_pkg::SEQ_STOP;
               st_nxt.pre_on = 1'b0;
            end
            else if (st_r.tmr == RUN_CYC - 1)
            begin
               st_nxt.seq = ies_pkg::SEQ_RUN;
               st_nxt.int_en = 1'b1;
            end
         end
         // running; withdrawal seen only after the 1 ms lag
         ies_pkg::SEQ_RUN:
         begin
            if (!start_lag)
            begin
               st_nxt.seq = ies_pkg::SEQ_STOP;
               st_nxt.int_en = 1'b0;
            end
         end
         // pulses already inhibited, now drop the line contactor
         ies_pkg::SEQ_STOP:
         begin
            st_nxt.int_en = 1'b0;
            st_nxt.line_on = 1'b0;
            st_nxt.pre_on = 1'b0;
            st_nxt.seq = ies_pkg::SEQ_IDLE;
         end
      endcase

      // open loop isolates the link; sequence restarts from idle
      if (!loop_ok && st_r.line_on)
      begin
         st_nxt.seq = ies_pkg::SEQ_IDLE;
         st_nxt.line_on = 1'b0;
         st_nxt.int_en = 1'b0;
      end

      // braking after drive inhibit, timed in milliseconds
      if (drive_lag || !pulse_lag || !st_r.int_en)
      begin
         // pulse withdrawal ends any braking at once: coasting
         st_nxt.brake_done = !drive_lag;
         st_nxt.brake_ms = '0;
         st_nxt.ms_div = '0;
      end
      else
      begin
         st_nxt.ms_div = tick_ms ? '0 : st_r.ms_div + 32'h0000_0001;
         if (tick_ms && st_r.brake_ms != 16'hFFFF)
            st_nxt.brake_ms = st_r.brake_ms + 16'h0001;
         if (cancel_speed || cancel_timer)
            st_nxt.brake_done = 1'b1;
      end

      // register writes, taken in the access phase
      if (access_ph && apb_req.pwrite)
      begin
         unique case (apb_req.paddr)
            ies_pkg::ADDR_BRAKE_CTRL:
               st_nxt.brake_ctrl = apb_req.pwdata[1:0];
            ies_pkg::ADDR_SPEED_THR:
               st_nxt.speed_thr = apb_req.pwdata[15:0];
            ies_pkg::ADDR_BRAKE_TMR:
               st_nxt.brake_tmr = apb_req.pwdata[15:0];
            default:
               st_nxt.brake_ctrl = st_r.brake_ctrl; // status, unmapped
         endcase
      end

      // read data captured in setup so it comes from a flop
      if (setup_ph)
      begin
         unique case (apb_req.paddr)
            ies_pkg::ADDR_STATUS:
               st_nxt.rdata = {21'h000000, st_r.brake_done, drive_lag,
                               pulse_lag, start_lag, charged,
                               st_r.int_en, st_r.line_on, st_r.pre_on,
                               3'(st_r.seq)};
            ies_pkg::ADDR_BRAKE_CTRL:
               st_nxt.rdata = {30'h00000000, st_r.brake_ctrl};
            ies_pkg::ADDR_SPEED_THR:
               st_nxt.rdata = {16'h0000, st_r.speed_thr};
            ies_pkg::ADDR_BRAKE_TMR:
               st_nxt.rdata = {16'h0000, st_r.brake_tmr};
            default:
               st_nxt.rdata = 32'h0000_0000;
         endcase
      end

      // synchronous reset: idle, contactors open, all inhibited
      if (sync_reset)
      begin
         st_nxt.seq = ies_pkg::SEQ_IDLE;
         st_nxt.tmr = '0;
         st_nxt.line_on = 1'b0;
         st_nxt.pre_on = 1'b0;
         st_nxt.int_en = 1'b0;
         st_nxt.brake_done = 1'b0;
         st_nxt.ms_div = '0;
         st_nxt.brake_ms = '0;
      end
   end

   //============================================================
   // state register
   //============================================================
   // async reset to constants; ce freezes everything
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
         st_r.brake_ctrl <= ies_pkg::BRAKE_CTRL_RST;
         st_r.speed_thr <= ies_pkg::SPEED_THR_RST;
         st_r.brake_tmr <= ies_pkg::BRAKE_TMR_RST;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
      end
   end

   //============================================================
   // outputs
   //============================================================
   // coil drive is broken by the external loop without delay
   assign contactor_loop_out = st_r.line_on && contactor_loop_in;
   assign precharge_on = st_r.pre_on;

   // start gates every output but setpoint_zero; pulse enable then has top priority
   always_comb
   begin
      enables.internal_en = st_r.int_en;
      enables.infeed_pulse_en = st_r.int_en && pulse_lag;
      // link stays unregulated while infeed pulses are inhibited
      enables.regulated = st_r.int_en && pulse_lag;
      enables.drive_pulse_en = st_r.int_en && pulse_lag &&
                               (drive_lag || !st_r.brake_done);
      enables.setpoint_zero = !drive_lag;
      // spindles decelerate only through regenerative limiting
      enables.regen_limit = st_r.int_en && pulse_lag && !drive_lag &&
                            !st_r.brake_done;
   end

endmodule : ies_sequencer
`default_nettype wire

// file: ies_pkg.sv
//============================================================
// contract
//============================================================
package ies_pkg;

   //============================================================
   // clock and times
   //============================================================
   localparam int unsigned CLK_HZ = 25_000_000; // system clock rate
   localparam int unsigned T_EDGE_US = 1000; // enable input lag, us
   localparam int unsigned T_SWAP_MS = 500; // charge to contactor swap
   localparam int unsigned T_RUN_MS = 1000; // charge to internal enables
   localparam int unsigned T_EDGE_CYC = T_EDGE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned T_SWAP_CYC = T_SWAP_MS * (CLK_HZ / 1000);
   localparam int unsigned T_RUN_CYC = T_RUN_MS * (CLK_HZ / 1000);
   localparam int unsigned T_MS_CYC = CLK_HZ / 1000; // brake timer tick

   //============================================================
   // voltage checks, in volts
   //============================================================
   localparam logic [15:0] V_MIN_LINK = 16'h012C; // 300 V floor
   localparam logic [15:0] V_MARGIN = 16'h0032; // 50 V below peak
   localparam logic [7:0] SQRT2_NUM = 8'hB5; // root two as 181/128
   localparam int unsigned SQRT2_SHIFT = 7;

   //============================================================
   // register map, byte addresses
   //============================================================
   localparam logic [7:0] ADDR_STATUS = 8'h00; // read-only state
   localparam logic [7:0] ADDR_BRAKE_CTRL = 8'h04; // cancel selects
   localparam logic [7:0] ADDR_SPEED_THR = 8'h08; // speed threshold
   localparam logic [7:0] ADDR_BRAKE_TMR = 8'h0C; // timer stage, ms
   localparam logic [1:0] BRAKE_CTRL_RST = 2'h3; // both selects on
   localparam logic [15:0] SPEED_THR_RST = 16'h0010;
   localparam logic [15:0] BRAKE_TMR_RST = 16'h03E8; // 1000 ms
   localparam int unsigned BC_SPEED_BIT = 0; // cancel on low speed
   localparam int unsigned BC_TIMER_BIT = 1; // cancel on timer

   // sequencer states
   typedef enum logic [2:0] {
      SEQ_IDLE, SEQ_CHARGE, SEQ_SETTLE, SEQ_RUN, SEQ_STOP
   } ies_seq_t;

   // apb request from master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ies_apb_req_t;

   // enable outputs toward the modules
   typedef struct packed {
      logic internal_en; // internal enable signals issued
      logic infeed_pulse_en; // infeed power stage pulses
      logic drive_pulse_en; // drive power stage pulses
      logic setpoint_zero; // speed setpoint forced to 0
      logic regen_limit; // spindle ramp by regen limiting
      logic regulated; // link in regulated mode
   } ies_enables_t;

endpackage : ies_pkg

// file: ies_lag.sv
`timescale 1ns/100ps
`default_nettype none
//============================================================
// level follower that copies its input after a fixed lag
//============================================================
module ies_lag #(
   parameter int unsigned LAG_CYC = 25000 // cycles a change must hold
) (
   // clock and resets
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic srst,
   // level in and out
   input wire logic din,
   output logic dout
);
   localparam int CW = $clog2(LAG_CYC + 1);

   // all state of this follower
   typedef struct packed {
      logic [CW-1:0] cnt; // cycles the input differs
      logic q; // followed level
   } ies_lag_st_t;

   ies_lag_st_t st_r;
   ies_lag_st_t st_nxt;

   // a glitch shorter than the lag restarts the count
   always_comb
   begin
      st_nxt = st_r;
      if (srst)
      begin
         st_nxt = '0;
      end
      else if (din == st_r.q)
      begin
         st_nxt.cnt = '0;
      end
      else if (st_r.cnt == CW'(LAG_CYC - 1))
      begin
         st_nxt.q = din;
         st_nxt.cnt = '0;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else if (ce)
         st_r <= st_nxt;
   end

   assign dout = st_r.q;

endmodule : ies_lag
`default_nettype wire

// file: ies_sequencer_sva.sv
`timescale 1ns/100ps
`default_nettype none
//======
// sequencer checker
module ies_sequencer_sva #(
   parameter int unsigned EDGE_CYC = 8, // input lag
   parameter int unsigned SWAP_CYC = 40, // charge to swap
   parameter int unsigned RUN_CYC = 80 // charge to enables
) (
   // clock, resets, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic sync_reset,
   // contacts
   input wire logic start_in,
   input wire logic pulse_en_in,
   input wire logic drive_en_in,
   input wire logic contactor_loop_in,
   // outputs watched
   input wire logic precharge_on,
   input wire logic contactor_loop_out,
   input wire ies_pkg::ies_enables_t enables
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // input run lengths, saturating
   logic [15:0] st_low_r;
   logic [15:0] pl_low_r;
   logic [15:0] dr_low_r;
   logic [15:0] dr_hi_r;
   logic [15:0] swap_r; // clocks since precharge dropped
   function automatic logic [15:0] bump(input logic [15:0] v);
      return v + {15'h0, ~&v};
   endfunction : bump
   // frozen with ce, as the lags are
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_low_r <= 16'h0000;
         pl_low_r <= 16'h0000;
         dr_low_r <= 16'h0000;
         dr_hi_r <= 16'h0000;
         swap_r <= 16'h0000;
      end
      else if (ce)
      begin
         st_low_r <= start_in ? 16'h0000 : bump(st_low_r);
         pl_low_r <= pulse_en_in ? 16'h0000 : bump(pl_low_r);
         dr_low_r <= drive_en_in ? 16'h0000 : bump(dr_low_r);
         // sync reset clears the lag
         dr_hi_r <= (drive_en_in && !sync_reset) ? bump(dr_hi_r) : 16'h0000;
         swap_r <= precharge_on ? 16'h0000 : bump(swap_r);
      end
   end
   loop_gate_a : assert property (!contactor_loop_in |-> !contactor_loop_out)
      else $error("contactor on with loop open");
   loop_drop_a : assert property (!contactor_loop_in && ce |=> !enables.internal_en)
      else $error("enables kept with loop open");
   swap_excl_a : assert property (!(precharge_on && contactor_loop_out))
      else $error("both contactors closed");
   run_delay_a : assert property ($rose(enables.internal_en) |-> swap_r == RUN_CYC - SWAP_CYC)
      else $error("enable delay wrong");
   stop_order_a : assert property ($fell(contactor_loop_out) && contactor_loop_in
      && !$past(sync_reset) |-> !$past(enables.infeed_pulse_en)) else $error("contactor before pulses");
   start_off_a : assert property (st_low_r > EDGE_CYC + 4 |-> !enables.internal_en && !contactor_loop_out)
      else $error("start low ignored");
   coast_a : assert property (pl_low_r > EDGE_CYC + 2
      |-> !(enables.infeed_pulse_en || enables.drive_pulse_en || enables.regen_limit)) else $error("no coast");
   zero_set_a : assert property (dr_low_r > EDGE_CYC + 2 |-> enables.setpoint_zero)
      else $error("setpoint not zero");
   drive_free_a : assert property (dr_hi_r > EDGE_CYC + 2 |-> !enables.setpoint_zero)
      else $error("drive not released");
   link_unreg_a : assert property (!enables.infeed_pulse_en |-> !enables.regulated)
      else $error("regulated without pulses");
   spindle_ramp_a : assert property (enables.regen_limit |-> enables.setpoint_zero)
      else $error("regen limit outside braking");
   sync_idle_a : assert property (sync_reset && ce |=> !precharge_on && !contactor_loop_out)
      else $error("sync reset not idle");
   cover property ($rose(enables.internal_en));
   cover property ($fell(enables.drive_pulse_en) && enables.setpoint_zero);
   cover property ($fell(contactor_loop_out));
endmodule : ies_sequencer_sva
bind ies_sequencer ies_sequencer_sva #(
   .EDGE_CYC(EDGE_CYC), .SWAP_CYC(SWAP_CYC), .RUN_CYC(RUN_CYC)
) i_ies_sequencer_sva (
   .clk(clk), .rst_n(rst_n), .ce(ce), .sync_reset(sync_reset), .start_in(start_in),
   .pulse_en_in(pulse_en_in), .drive_en_in(drive_en_in),
   .contactor_loop_in(contactor_loop_in), .precharge_on(precharge_on),
   .contactor_loop_out(contactor_loop_out), .enables(enables)
);
`default_nettype wire

// file: ies_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
//======
// controller contacts and dc link
module ies_ctrl_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bench commands
   input wire logic cmd_start,
   input wire logic cmd_pulse,
   input wire logic cmd_drive,
   input wire logic cmd_loop,
   input wire logic [15:0] vdc_goal,
   // contactors seen
   input wire logic precharge_on,
   input wire logic contactor_loop_out,
   // contacts and link voltage
   output logic start_in,
   output logic pulse_en_in,
   output logic drive_en_in,
   output logic contactor_loop_in,
   output logic [15:0] vdc_link
);
   // contacts lag one clock, like relays
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         start_in <= 1'b0;
         pulse_en_in <= 1'b0;
         drive_en_in <= 1'b0;
         contactor_loop_in <= 1'b0;
         vdc_link <= 16'h0000;
      end
      else
      begin
         start_in <= cmd_start;
         pulse_en_in <= cmd_pulse;
         drive_en_in <= cmd_drive;
         contactor_loop_in <= cmd_loop;
         // link charges only through a closed contactor
         if ((precharge_on || contactor_loop_out) && vdc_link < vdc_goal)
            vdc_link <= vdc_link + 16'h0010;
      end
   end
endmodule : ies_ctrl_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
//======
// sequencer bench
module tb_top;
   localparam int unsigned EDGE = 8; // shortened lag
   localparam int unsigned SWAP = 40;
   localparam int unsigned RUN = 80;
   localparam int unsigned MSC = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1; // always enabled
   logic sync_reset = 1'b0;
   ies_pkg::ies_apb_req_t apb_req = '0;
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
   logic cmd_start = 1'b0;
   logic cmd_pulse = 1'b0;
   logic cmd_drive = 1'b0;
   logic cmd_loop = 1'b1;
   logic [15:0] vdc_goal = 16'h0120; // 288 V
   logic [15:0] vline = 16'h0000;
   logic [15:0] drive_speed = 16'h0000;
   logic start_in;
   logic pulse_en_in;
   logic drive_en_in;
   logic contactor_loop_in;
   logic [15:0] vdc_link;
   logic precharge_on;
   logic contactor_loop_out;
   ies_pkg::ies_enables_t enables;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;
   always #20 clk = ~clk;
   ies_sequencer #(.EDGE_CYC(EDGE), .SWAP_CYC(SWAP), .RUN_CYC(RUN), .MS_CYC(MSC)) i_ies_sequencer (
      .clk(clk), .rst_n(rst_n), .ce(ce), .sync_reset(sync_reset), .apb_req(apb_req),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .start_in(start_in),
      .pulse_en_in(pulse_en_in), .drive_en_in(drive_en_in),
      .contactor_loop_in(contactor_loop_in), .vdc_link(vdc_link), .vline(vline),
      .drive_speed(drive_speed), .precharge_on(precharge_on),
      .contactor_loop_out(contactor_loop_out), .enables(enables));
   ies_ctrl_model i_ies_ctrl_model (.clk(clk), .rst_n(rst_n), .cmd_start(cmd_start),
      .cmd_pulse(cmd_pulse), .cmd_drive(cmd_drive), .cmd_loop(cmd_loop),
      .vdc_goal(vdc_goal), .precharge_on(precharge_on),
      .contactor_loop_out(contactor_loop_out), .start_in(start_in),
      .pulse_en_in(pulse_en_in), .drive_en_in(drive_en_in),
      .contactor_loop_in(contactor_loop_in), .vdc_link(vdc_link));
   task automatic chk_bit(input logic act, input logic exp);
      chk_word(32'(act), 32'(exp));
   endtask : chk_bit
   task automatic chk_word(input logic [31:0] act, input logic [31:0] exp);
      checks_done++;
      if (act !== exp)
      begin
         miscompares++;
         $display("FAIL t=%0t got %0h exp %0h", $time, act, exp);
      end
   endtask : chk_word
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick
   // request held until the ready edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge clk);
      apb_req.psel <= 1'b1;
      apb_req.pwrite <= wr;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      @(posedge clk);
      apb_req.penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      q = prdata;
      e = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : reg_wr
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk_word(q, x);
      chk_bit(e, a > ies_pkg::ADDR_BRAKE_TMR);
   endtask : reg_chk
   // start, wait for swap, time the enables
   task automatic run_up();
      cmd_start <= 1'b1;
      while (precharge_on !== 1'b1) tick(1);
      while (contactor_loop_out !== 1'b1) tick(1);
      chk_bit(precharge_on, 1'b0);
      for (n = 0; enables.internal_en !== 1'b1; n++) tick(1);
      chk_word(32'(n), 32'(RUN - SWAP));
   endtask : run_up
   task automatic close_out();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         miscompares++;
         close_out();
      end
   end
   initial
   begin
      tick(10);
      rst_n <= 1'b1;
      reg_chk(ies_pkg::ADDR_BRAKE_CTRL, 32'(ies_pkg::BRAKE_CTRL_RST));
      reg_chk(ies_pkg::ADDR_SPEED_THR, 32'(ies_pkg::SPEED_THR_RST));
      reg_chk(ies_pkg::ADDR_BRAKE_TMR, 32'(ies_pkg::BRAKE_TMR_RST));
      reg_chk(8'h10, 32'h0000_0000);
      chk_bit(enables.setpoint_zero, 1'b1);
      $display("test registers done");
      // under 300 V, then under the line peak
      cmd_start <= 1'b1;
      tick(40);
      chk_bit(precharge_on, 1'b1);
      vline <= 16'h012C;
      vdc_goal <= 16'h0140;
      tick(40);
      chk_bit(contactor_loop_out, 1'b0);
      cmd_start <= 1'b0;
      tick(EDGE + 6);
      chk_bit(precharge_on, 1'b1);
      vdc_goal <= 16'h0190;
      tick(30);
      chk_bit(precharge_on, 1'b0);
      chk_bit(contactor_loop_out, 1'b0);
      $display("test charge done");
      cmd_pulse <= 1'b1;
      cmd_drive <= 1'b1;
      run_up();
      tick(1);
      chk_bit(enables.infeed_pulse_en, 1'b1);
      chk_bit(enables.regulated, 1'b1);
      $display("test power on done");
      // braking on low speed
      drive_speed <= 16'h0064;
      cmd_drive <= 1'b0;
      tick(EDGE - 2);
      chk_bit(enables.setpoint_zero, 1'b0);
      tick(6);
      chk_bit(enables.setpoint_zero, 1'b1);
      chk_bit(enables.regen_limit, 1'b1);
      chk_bit(enables.drive_pulse_en, 1'b1);
      drive_speed <= 16'h0005;
      tick(4);
      chk_bit(enables.drive_pulse_en, 1'b0);
      // braking on the timer only, 3 ms
      reg_wr(ies_pkg::ADDR_BRAKE_CTRL, 32'h0000_0002);
      reg_wr(ies_pkg::ADDR_BRAKE_TMR, 32'h0000_0003);
      drive_speed <= 16'h0064;
      cmd_drive <= 1'b1;
      tick(EDGE + 4);
      chk_bit(enables.drive_pulse_en, 1'b1);
      cmd_drive <= 1'b0;
      tick(EDGE + 4);
      chk_bit(enables.drive_pulse_en, 1'b1);
      tick(3 * MSC + 6);
      chk_bit(enables.drive_pulse_en, 1'b0);
      $display("test braking done");
      cmd_drive <= 1'b1;
      tick(EDGE + 4);
      cmd_pulse <= 1'b0;
      tick(EDGE - 2);
      chk_bit(enables.infeed_pulse_en, 1'b1);
      tick(6);
      chk_bit(enables.infeed_pulse_en, 1'b0);
      chk_bit(enables.drive_pulse_en, 1'b0);
      chk_bit(enables.regulated, 1'b0);
      cmd_pulse <= 1'b1;
      tick(EDGE + 4);
      chk_bit(enables.regulated, 1'b1);
      $display("test pulses done");
      // a short dip of start is filtered
      cmd_start <= 1'b0;
      tick(3);
      cmd_start <= 1'b1;
      tick(EDGE + 4);
      chk_bit(enables.internal_en, 1'b1);
      cmd_start <= 1'b0;
      tick(EDGE + 6);
      chk_bit(enables.internal_en, 1'b0);
      chk_bit(contactor_loop_out, 1'b0);
      chk_bit(enables.infeed_pulse_en, 1'b0);
      $display("test stop done");
      run_up();
      cmd_loop <= 1'b0;
      tick(3);
      chk_bit(contactor_loop_out, 1'b0);
      chk_bit(enables.internal_en, 1'b0);
      cmd_start <= 1'b0;
      cmd_loop <= 1'b1;
      sync_reset <= 1'b1;
      tick(1);
      sync_reset <= 1'b0;
      tick(1);
      chk_bit(precharge_on, 1'b0);
      chk_bit(enables.setpoint_zero, 1'b1);
      reg_chk(ies_pkg::ADDR_BRAKE_TMR, 32'h0000_0003);
      $display("test loop and sync reset done");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
